// ### rtl/wecu_top.sv
`timescale 1ns/1ps
`include "wecu_consts.svh"
module wecu_top #(
	parameter int EVENT_DELAY_CYCLES = `WECU_EVENT_DELAY_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic wake_pin,
	input wire logic sck,
	input wire logic scsn_b,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire logic [7:0] sys_event,
	input wire logic [7:0] sup_event,
	input wire logic [7:0] trx_event,
	input wire logic can_wake_event,
	input wire wecu_pkg::wecu_mode_type sbc_mode,
	input wire logic can_offline,
	input wire logic io_supply_on,
	input wire logic sleep_disable_bit,
	input wire logic sleep_cmd,
	output logic rxd_low,
	output logic enter_sleep,
	output logic goto_reset,
	output logic system_reset,
	output logic wake_request
);
	wecu_pkg::wecu_state_type s;
	wecu_pkg::wecu_state_type next_s;
	wecu_pkg::wecu_write_type wr;
	logic [3:0] pins_s;
	logic wake_s;
	logic spi_fail;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] clr_sys;
	logic [7:0] clr_sup;
	logic [7:0] clr_trx;
	logic [7:0] clr_wake;
	logic [7:0] cap_sys;
	logic [7:0] cap_sup;
	logic [7:0] cap_trx;
	logic [7:0] cap_wake;
	logic [7:0] src_sys;
	logic [7:0] src_trx;
	logic [7:0] src_wake;
	logic [7:0] wa;
	logic [7:0] wd;
	logic rise;
	logic fall;
	logic slp_fail;
	logic cleared_any;
	logic captured_any;
	logic pending;
	logic pending_next;
	logic regular_en;
	logic stop_mode;
	logic signal_ok;
	logic level_ok;

	// ---------------------------------------------
	// pin synchronisers and register link
	// ---------------------------------------------
	wecu_sync #(
		.WIDTH(4),
		.RST_VAL(4'h4)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.async_in({wake_pin, scsn_b, sck, sdi}),
		.sync_out(pins_s)
	);

	assign wake_s = pins_s[3];

	wecu_spi u_spi (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.sck_s(pins_s[1]),
		.scsn_s(pins_s[2]),
		.sdi_s(pins_s[0]),
		.rd_data(rd_data),
		.rd_addr(rd_addr),
		.wr(wr),
		.spi_fail(spi_fail),
		.sdo(sdo),
		.sdo_oe(sdo_oe)
	);

	// ---------------------------------------------
	// read mux, no read side effects
	// ---------------------------------------------
	assign level_ok = (sbc_mode == wecu_pkg::wecu_mode_normal)
		|| (|s.wake_en[`WECU_WAKE_RISE_BIT:`WECU_WAKE_FALL_BIT]);

	always_comb
	begin
		rd_data = 8'h00;
		case ({1'b0, rd_addr})
			`WECU_ADDR_SYS_EN: rd_data = s.sys_en;
			`WECU_ADDR_SUP_EN: rd_data = s.sup_en;
			`WECU_ADDR_TRX_EN: rd_data = s.trx_en;
			`WECU_ADDR_WAKE_EN: rd_data = s.wake_en;
			`WECU_ADDR_LEVEL: rd_data[`WECU_LEVEL_BIT] = level_ok & wake_s;
			`WECU_ADDR_GLOBAL:
			begin
				rd_data[0] = |s.sys_flags;
				rd_data[1] = |s.sup_flags;
				rd_data[2] = |s.trx_flags;
				rd_data[3] = |s.wake_flags;
			end
			`WECU_ADDR_SYS_FLAGS: rd_data = s.sys_flags;
			`WECU_ADDR_SUP_FLAGS: rd_data = s.sup_flags;
			`WECU_ADDR_TRX_FLAGS: rd_data = s.trx_flags;
			`WECU_ADDR_WAKE_FLAGS: rd_data = s.wake_flags;
			default: rd_data = 8'h00;
		endcase
	end

	// ---------------------------------------------
	// event capture, delay timer and sleep guard
	// ---------------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.sleep_out = '0;
		clr_sys = 8'h00;
		clr_sup = 8'h00;
		clr_trx = 8'h00;
		clr_wake = 8'h00;
		wa = 8'h00;
		wd = 8'h00;

		// first sample after reset only arms the edge detector
		rise = s.wake_ok & ~s.wake_prev & wake_s;
		fall = s.wake_ok & s.wake_prev & ~wake_s;
		next_s.wake_prev = wake_s;
		next_s.wake_ok = 1'b1;

		// register writes, bytes past the map are dropped
		for (int i = 0; i < 3; i++)
		begin
			wa = {1'b0, wr.addr} + 8'(i);
			wd = wr.data[8*i +: 8];
			if (wr.valid && (2'(i) < wr.nbytes))
			begin
				case (wa)
					`WECU_ADDR_SYS_EN: next_s.sys_en = wd & `WECU_SYS_EN_MASK;
					`WECU_ADDR_SUP_EN: next_s.sup_en = wd & `WECU_SUP_EN_MASK;
					`WECU_ADDR_TRX_EN: next_s.trx_en = wd & `WECU_TRX_EN_MASK;
					`WECU_ADDR_WAKE_EN: next_s.wake_en = wd & `WECU_WAKE_EN_MASK;
					`WECU_ADDR_SYS_FLAGS: clr_sys = wd;
					`WECU_ADDR_SUP_FLAGS: clr_sup = wd;
					`WECU_ADDR_TRX_FLAGS: clr_trx = wd;
					`WECU_ADDR_WAKE_FLAGS: clr_wake = wd;
					default: ;
				endcase
			end
		end

		pending = (|s.sys_flags) | (|s.sup_flags) | (|s.trx_flags)
			| (|s.wake_flags);
		regular_en = s.trx_en[`WECU_TRX_CW_BIT]
			| s.wake_en[`WECU_WAKE_RISE_BIT] | s.wake_en[`WECU_WAKE_FALL_BIT];

		// sleep guard, disable bit first since it leaves the mode alone
		slp_fail = 1'b0;
		if (sleep_cmd)
		begin
			if (sleep_disable_bit)
				slp_fail = 1'b1;
			else if (!regular_en)
				next_s.sleep_out.system_reset = 1'b1;
			else if (pending)
				next_s.sleep_out.goto_reset = 1'b1;
			else
				next_s.sleep_out.enter_sleep = 1'b1;
		end

		// capture sources gated by enables, fixed sources bypass them
		src_sys = sys_event;
		src_sys[`WECU_SYS_SPIF_BIT] = sys_event[`WECU_SYS_SPIF_BIT] | spi_fail | slp_fail;
		src_trx = trx_event;
		src_trx[`WECU_TRX_CW_BIT] = trx_event[`WECU_TRX_CW_BIT] | can_wake_event;
		src_wake = 8'h00;
		src_wake[`WECU_WAKE_RISE_BIT] = rise;
		src_wake[`WECU_WAKE_FALL_BIT] = fall;
		cap_sys = src_sys & (s.sys_en | `WECU_SYS_ALWAYS);
		cap_sup = sup_event & s.sup_en;
		cap_trx = src_trx & (s.trx_en | `WECU_TRX_ALWAYS);
		cap_wake = src_wake & s.wake_en;

		// set beats clear when both land in one cycle
		next_s.sys_flags = (s.sys_flags & ~clr_sys) | cap_sys;
		next_s.sup_flags = (s.sup_flags & ~clr_sup) | cap_sup;
		next_s.trx_flags = (s.trx_flags & ~clr_trx) | cap_trx;
		next_s.wake_flags = (s.wake_flags & ~clr_wake) | cap_wake;

		cleared_any = (|(s.sys_flags & clr_sys)) | (|(s.sup_flags & clr_sup))
			| (|(s.trx_flags & clr_trx)) | (|(s.wake_flags & clr_wake));
		captured_any = (|cap_sys) | (|cap_sup) | (|cap_trx) | (|cap_wake);
		pending_next = (|next_s.sys_flags) | (|next_s.sup_flags)
			| (|next_s.trx_flags) | (|next_s.wake_flags);

		if (captured_any && sbc_mode == wecu_pkg::wecu_mode_sleep)
			next_s.sleep_out.wake_request = 1'b1;

		// delay timer
		stop_mode = (sbc_mode == wecu_pkg::wecu_mode_reset)
			|| (sbc_mode == wecu_pkg::wecu_mode_sleep)
			|| (sbc_mode == wecu_pkg::wecu_mode_overtemp)
			|| (sbc_mode == wecu_pkg::wecu_mode_off);
		if (stop_mode)
		begin
			next_s.delay_run = 1'b0;
			next_s.delay_cnt = '0;
		end
		else if (cleared_any)
		begin
			next_s.delay_run = 1'b1;
			next_s.delay_cnt = '0;
		end
		else if (s.delay_run)
		begin
			if (s.delay_cnt == `WECU_DELAY_W'(EVENT_DELAY_CYCLES - 1))
				next_s.delay_run = 1'b0;
			else
				next_s.delay_cnt = s.delay_cnt + `WECU_DELAY_W'(1);
		end

		// pin is only pulled while the host can see it
		signal_ok = can_offline && io_supply_on
			&& ((sbc_mode == wecu_pkg::wecu_mode_normal)
			|| (sbc_mode == wecu_pkg::wecu_mode_standby)
			|| (sbc_mode == wecu_pkg::wecu_mode_sleep));
		next_s.rxd_low = signal_ok && pending_next && !next_s.delay_run;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '0;
			s.sys_en <= `WECU_EN_RESET;
			s.sup_en <= `WECU_EN_RESET;
			s.trx_en <= `WECU_EN_RESET;
			s.wake_en <= `WECU_EN_RESET;
			s.sys_flags <= `WECU_SYS_FLAGS_RESET;
			s.sup_flags <= `WECU_FLAGS_RESET;
			s.trx_flags <= `WECU_FLAGS_RESET;
			s.wake_flags <= `WECU_FLAGS_RESET;
		end
		else
			s <= next_s;
	end

	assign rxd_low = s.rxd_low;
	assign enter_sleep = s.sleep_out.enter_sleep;
	assign goto_reset = s.sleep_out.goto_reset;
	assign system_reset = s.sleep_out.system_reset;
	assign wake_request = s.sleep_out.wake_request;
endmodule

// ### rtl/wecu_consts.svh
`ifndef WECU_CONSTS_SVH
`define WECU_CONSTS_SVH
// Summary of operation
// - wake pin rising or falling edge raises an event per its enable
// - wake level bit always valid in normal mode, else when an edge is enabled
// - power-on, watchdog fail and frame-detect-error events are always captured
// - every other event is captured only when its enable bit is set
// - captured event sets its status flag, held until software clears it
// - with CAN offline, io supply up and mode normal, standby or sleep, receive-data pin driven low on events
// - capture during sleep requests application supply and standby via reset
// - global summary register shows one bit per event group
// - writing 1 clears a flag, 0 has no effect, many bits per write
// - clearing any flag releases the receive-data pin and starts the delay timer
// - events still captured while timing; pending events re-assert the pin at expiry
// - nothing pending at expiry leaves the pin high
// - status and enable registers readable at any time
// - timer stops in reset, sleep, overtemp, off; pending event signalled in sleep
// - can wake and wake pin edge captures are disabled after power-on
// - sleep request with no regular wake enabled causes a system reset
// - sleep request with any flag pending goes to reset mode instead
// - sleep request with sleep disabled raises spi failure, mode unchanged

// ---------------------------------------------
// register addresses
// ---------------------------------------------
`define WECU_ADDR_SYS_EN 8'h04
`define WECU_ADDR_SUP_EN 8'h1c
`define WECU_ADDR_TRX_EN 8'h23
`define WECU_ADDR_LEVEL 8'h4b
`define WECU_ADDR_WAKE_EN 8'h4c
`define WECU_ADDR_GLOBAL 8'h60
`define WECU_ADDR_SYS_FLAGS 8'h61
`define WECU_ADDR_SUP_FLAGS 8'h62
`define WECU_ADDR_TRX_FLAGS 8'h63
`define WECU_ADDR_WAKE_FLAGS 8'h64

// ---------------------------------------------
// field positions and masks
// ---------------------------------------------
`define WECU_SYS_WDF_BIT 0
`define WECU_SYS_SPIF_BIT 1
`define WECU_SYS_PO_BIT 4
`define WECU_TRX_CW_BIT 0
`define WECU_TRX_FRAME_DETECT_ERROR_FLAG_BIT 5
`define WECU_WAKE_FALL_BIT 0
`define WECU_WAKE_RISE_BIT 1
`define WECU_LEVEL_BIT 1
`define WECU_SYS_ALWAYS 8'h11
`define WECU_TRX_ALWAYS 8'h20
`define WECU_SYS_EN_MASK 8'hee
`define WECU_SUP_EN_MASK 8'hff
`define WECU_TRX_EN_MASK 8'hdf
`define WECU_WAKE_EN_MASK 8'h03
`define WECU_EN_RESET 8'h00
`define WECU_SYS_FLAGS_RESET 8'h10
`define WECU_FLAGS_RESET 8'h00

// ---------------------------------------------
// timing
// ---------------------------------------------
`define WECU_CLK_PERIOD_NS 40
`define WECU_EVENT_DELAY_NS 10000000
`define WECU_EVENT_DELAY_CYC (`WECU_EVENT_DELAY_NS / `WECU_CLK_PERIOD_NS)
`define WECU_DELAY_W 20
`endif

// ### rtl/wecu_pkg.sv
package wecu_pkg;
	typedef enum logic [2:0] {
		wecu_mode_normal = 3'b000,
		wecu_mode_standby = 3'b001,
		wecu_mode_sleep = 3'b010,
		wecu_mode_reset = 3'b011,
		wecu_mode_overtemp = 3'b100,
		wecu_mode_off = 3'b101,
		wecu_mode_forced = 3'b110
	} wecu_mode_type;

	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [1:0] nbytes;
		logic [23:0] data;
	} wecu_write_type;

	typedef struct packed {
		logic enter_sleep;
		logic goto_reset;
		logic system_reset;
		logic wake_request;
	} wecu_sleep_out_type;

	typedef struct packed {
		logic sck_prev;
		logic scsn_prev;
		logic [5:0] cnt;
		logic [7:0] sh_in;
		logic [7:0] sh_out;
		logic ro;
		logic [6:0] rd_ptr;
		logic load;
		logic sdo;
		logic sdo_oe;
		logic fail;
		wecu_write_type wr;
	} wecu_spi_state_type;

	typedef struct packed {
		logic [7:0] sys_en;
		logic [7:0] sup_en;
		logic [7:0] trx_en;
		logic [7:0] wake_en;
		logic [7:0] sys_flags;
		logic [7:0] sup_flags;
		logic [7:0] trx_flags;
		logic [7:0] wake_flags;
		logic [19:0] delay_cnt;
		logic delay_run;
		logic rxd_low;
		logic wake_prev;
		logic wake_ok;
		wecu_sleep_out_type sleep_out;
	} wecu_state_type;
endpackage

// ### rtl/wecu_sync.sv
`timescale 1ns/1ps
module wecu_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} wecu_sync_state_type;

	wecu_sync_state_type s;
	wecu_sync_state_type next_s;

	// first stage feeds only the second
	always_comb
	begin
		next_s.meta = async_in;
		next_s.sync = s.meta;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			s <= {RST_VAL, RST_VAL};
		else
			s <= next_s;
	end

	assign sync_out = s.sync;
endmodule

// ### rtl/wecu_spi.sv
`timescale 1ns/1ps
module wecu_spi (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic sck_s,
	input wire logic scsn_s,
	input wire logic sdi_s,
	input wire logic [7:0] rd_data,
	output logic [6:0] rd_addr,
	output wecu_pkg::wecu_write_type wr,
	output logic spi_fail,
	output logic sdo,
	output logic sdo_oe
);
	wecu_pkg::wecu_spi_state_type s;
	wecu_pkg::wecu_spi_state_type next_s;
	logic [7:0] sin;
	logic len_ok;

	// ---------------------------------------------
	// frame engine, sample on falling sck, shift on rising
	// ---------------------------------------------
	always_comb
	begin
		next_s = s;
		sin = {s.sh_in[6:0], sdi_s};
		len_ok = (s.cnt == 6'd16) || (s.cnt == 6'd24) || (s.cnt == 6'd32);
		next_s.wr.valid = 1'b0;
		next_s.fail = 1'b0;
		next_s.load = 1'b0;
		next_s.sck_prev = sck_s;
		next_s.scsn_prev = scsn_s;
		next_s.sdo_oe = ~scsn_s;
		if (s.load)
			next_s.sh_out = rd_data;
		if (scsn_s)
		begin
			// writes commit only at deselect, so a torn frame writes nothing
			if (!s.scsn_prev && !s.ro && s.cnt != 6'd0)
			begin
				if (len_ok)
				begin
					next_s.wr.valid = 1'b1;
					next_s.wr.nbytes = 2'(s.cnt[5:3] - 3'd1);
				end
				else
					next_s.fail = 1'b1;
			end
			next_s.cnt = 6'd0;
			next_s.ro = 1'b0;
			next_s.sh_out = 8'h00;
		end
		else
		begin
			if (s.sck_prev && !sck_s)
			begin
				next_s.sh_in = sin;
				if (s.cnt != 6'd63)
					next_s.cnt = s.cnt + 6'd1;
				if (s.cnt[2:0] == 3'd7)
				begin
					next_s.load = 1'b1;
					case (s.cnt[5:3])
						3'd0:
						begin
							next_s.wr.addr = sin[7:1];
							next_s.ro = sin[0];
							next_s.rd_ptr = sin[7:1];
						end
						3'd1:
						begin
							next_s.wr.data[7:0] = sin;
							next_s.rd_ptr = s.rd_ptr + 7'd1;
						end
						3'd2:
						begin
							next_s.wr.data[15:8] = sin;
							next_s.rd_ptr = s.rd_ptr + 7'd1;
						end
						3'd3:
						begin
							next_s.wr.data[23:16] = sin;
							next_s.rd_ptr = s.rd_ptr + 7'd1;
						end
						default:
							next_s.load = 1'b0;
					endcase
				end
			end
			if (!s.sck_prev && sck_s)
			begin
				next_s.sdo = s.sh_out[7];
				next_s.sh_out = {s.sh_out[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '0;
			s.sck_prev <= 1'b0;
			s.scsn_prev <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign rd_addr = s.rd_ptr;
	assign wr = s.wr;
	assign spi_fail = s.fail;
	assign sdo = s.sdo;
	assign sdo_oe = s.sdo_oe;
endmodule

// ### bench/wecu_props.sv
`timescale 1ns/1ps
module wecu_props #(
	parameter int EVENT_DELAY_CYCLES = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic scsn_b,
	input wire logic sdo_oe,
	input wire wecu_pkg::wecu_mode_type sbc_mode,
	input wire logic can_offline,
	input wire logic io_supply_on,
	input wire logic sleep_disable_bit,
	input wire logic sleep_cmd,
	input wire logic rxd_low,
	input wire logic enter_sleep,
	input wire logic goto_reset,
	input wire logic system_reset,
	input wire logic wake_request
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// low time of the alert line
	// ----------------------------------------
	// only a low spell in normal mode with the line allowed throughout is a timer spell
	logic [19:0] low_cnt;
	logic timed;
	logic ok;
	assign ok = can_offline && io_supply_on && sbc_mode == wecu_pkg::wecu_mode_normal;
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			low_cnt <= 20'h0_0000;
			timed <= 1'b0;
		end
		else
		begin
			low_cnt <= rxd_low ? 20'h0_0000 : low_cnt + 20'h0_0001;
			timed <= (rxd_low || timed) && ok;
		end
	end
	a_sleep_disabled_hold: assert property (sleep_cmd && sleep_disable_bit |=>
		!(enter_sleep || goto_reset || system_reset)) else $error("sleep outcome while disabled");
	a_sleep_one_outcome: assert property (sleep_cmd && !sleep_disable_bit |=>
		$onehot({enter_sleep, goto_reset, system_reset})) else $error("sleep request outcome not single");
	a_sleep_no_cause: assert property (!sleep_cmd |=>
		!(enter_sleep || goto_reset || system_reset)) else $error("sleep outcome without request");
	a_wake_only_sleep: assert property (wake_request |->
		$past(sbc_mode) == wecu_pkg::wecu_mode_sleep) else $error("wake request outside sleep");
	a_rxd_supply_gate: assert property (rxd_low |->
		$past(can_offline) && $past(io_supply_on)) else $error("alert without offline and io supply");
	a_rxd_mode_gate: assert property (rxd_low |->
		$past(sbc_mode) <= wecu_pkg::wecu_mode_sleep) else $error("alert in stopped mode");
	a_delay_min_low: assert property ($rose(rxd_low) && timed |->
		int'(low_cnt) >= EVENT_DELAY_CYCLES) else $error("alert back before delay ran out");
	a_sdo_released: assert property (scsn_b [*5] |-> !sdo_oe)
		else $error("data out driven while deselected");
endmodule

bind wecu_top wecu_props #(.EVENT_DELAY_CYCLES(EVENT_DELAY_CYCLES)) props (.ref_clk, .rst_b, .scsn_b,
	.sdo_oe, .sbc_mode, .can_offline, .io_supply_on, .sleep_disable_bit, .sleep_cmd, .rxd_low,
	.enter_sleep, .goto_reset, .system_reset, .wake_request);

// ### bench/wecu_host.sv
`timescale 1ns/1ps
module wecu_host (
	input wire logic ref_clk,
	output logic sck,
	output logic scsn_b,
	output logic sdi,
	input wire logic sdo
);
	initial
	begin
		sck = 1'b0;
		scsn_b = 1'b1;
		sdi = 1'b0;
	end
	// ----------------------------------------
	// one frame, msb first
	// ----------------------------------------
	// ten cycles per half period: the pins pass a two-flop synchroniser
	task automatic xfer(input logic [15:0] w, input int nb, output logic [7:0] q);
		@(posedge ref_clk) #1;
		scsn_b = 1'b0;
		for (int i = 0; i < nb; i++)
		begin
			repeat (10) @(posedge ref_clk);
			#1 sck = 1'b1;
			sdi = w[15-i];
			repeat (10) @(posedge ref_clk);
			#1 sck = 1'b0;
			q = {q[6:0], sdo};
		end
		repeat (10) @(posedge ref_clk);
		#1 scsn_b = 1'b1;
		sdi = ~sdi;
		repeat (8) @(posedge ref_clk);
		#1;
	endtask
endmodule

// ### bench/test_wecu_top.sv
`timescale 1ns/1ps
module test_wecu_top;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic wake_pin = 1'b0;
	logic sck;
	logic scsn_b;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic [7:0] sys_event = 8'h00;
	logic [7:0] sup_event = 8'h00;
	logic [7:0] trx_event = 8'h00;
	logic can_wake_event = 1'b0;
	wecu_pkg::wecu_mode_type sbc_mode = wecu_pkg::wecu_mode_normal;
	logic can_offline = 1'b1;
	logic io_supply_on = 1'b1;
	logic sleep_disable_bit = 1'b0;
	logic sleep_cmd = 1'b0;
	logic rxd_low;
	logic enter_sleep;
	logic goto_reset;
	logic system_reset;
	logic wake_request;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	// short delay count keeps the run brief
	wecu_top #(.EVENT_DELAY_CYCLES(8)) DUT (.ref_clk, .rst_b, .wake_pin, .sck, .scsn_b, .sdi, .sdo,
		.sdo_oe, .sys_event, .sup_event, .trx_event, .can_wake_event, .sbc_mode, .can_offline,
		.io_supply_on, .sleep_disable_bit, .sleep_cmd, .rxd_low, .enter_sleep, .goto_reset,
		.system_reset, .wake_request);
	wecu_host host (.ref_clk, .sck, .scsn_b, .sdi, .sdo);
	initial
	begin
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		host.xfer({a[6:0], 1'b1, 8'h00}, 16, q);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.xfer({a[6:0], 1'b0, d}, 16, q);
	endtask
	task automatic cr(input logic e);
		chk("rxd_low", {7'h00, e}, {7'h00, rxd_low});
	endtask
	task automatic ev(input logic [7:0] s, input logic [7:0] u, input logic [7:0] t, input logic c);
		@(posedge ref_clk) #1;
		{sys_event, sup_event, trx_event, can_wake_event} = {s, u, t, c};
		@(posedge ref_clk) #1;
		{sys_event, sup_event, trx_event, can_wake_event} = '0;
	endtask
	task automatic sc(input logic [2:0] e);
		@(posedge ref_clk) #1;
		sleep_cmd = 1'b1;
		@(posedge ref_clk) #1;
		sleep_cmd = 1'b0;
		chk("sleep outcome", {5'h00, e}, {5'h00, enter_sleep, goto_reset, system_reset});
	endtask
	// one edge is enough: the alert flop follows mode and supply at once
	task automatic mc(input wecu_pkg::wecu_mode_type m, input logic io, input logic e);
		sbc_mode = m;
		io_supply_on = io;
		@(posedge ref_clk) #1;
		cr(e);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(8'h04, 8'h00);
		rd(8'h4c, 8'h00);
		rd(8'h23, 8'h00);
		rd(8'h61, 8'h10);
		rd(8'h60, 8'h01);
		cr(1'b1);
		wr(8'h61, 8'h10);
		rd(8'h61, 8'h00);
		cr(1'b0);
	endtask
	task automatic t_capture();
		ev(8'hff, 8'hff, 8'hff, 1'b1);
		cr(1'b1);
		rd(8'h61, 8'h11);
		rd(8'h62, 8'h00);
		rd(8'h63, 8'h20);
		rd(8'h60, 8'h05);
		can_offline = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 cr(1'b0);
		can_offline = 1'b1;
		wr(8'h63, 8'h20);
		cr(1'b0);
		repeat (20) @(posedge ref_clk);
		#1 cr(1'b1);
		wr(8'h61, 8'h11);
		rd(8'h60, 8'h00);
		cr(1'b0);
	endtask
	task automatic t_enable();
		wr(8'h1c, 8'hff);
		ev(8'h00, 8'h81, 8'h00, 1'b0);
		rd(8'h62, 8'h81);
		wr(8'h62, 8'h01);
		rd(8'h62, 8'h80);
		wr(8'h62, 8'h80);
		wr(8'h04, 8'hff);
		rd(8'h04, 8'hee);
		wr(8'h4c, 8'h03);
		rd(8'h4c, 8'h03);
		wake_pin = 1'b1;
		rd(8'h64, 8'h02);
		rd(8'h4b, 8'h02);
		wake_pin = 1'b0;
		rd(8'h64, 8'h03);
		rd(8'h4b, 8'h00);
		wr(8'h64, 8'h03);
	endtask
	task automatic t_sleep();
		sleep_disable_bit = 1'b1;
		sc(3'b000);
		rd(8'h61, 8'h02);
		sleep_disable_bit = 1'b0;
		sc(3'b010);
		wr(8'h61, 8'h02);
		sc(3'b100);
		wr(8'h4c, 8'h00);
		sc(3'b001);
		wr(8'h4c, 8'h03);
	endtask
	task automatic t_wake();
		logic seen;
		seen = 1'b0;
		sbc_mode = wecu_pkg::wecu_mode_sleep;
		wake_pin = 1'b1;
		repeat (10)
		begin
			@(posedge ref_clk) #1;
			seen = seen | wake_request;
		end
		chk("wake_request", 8'h01, {7'h00, seen});
		cr(1'b1);
		sbc_mode = wecu_pkg::wecu_mode_reset;
		repeat (2) @(posedge ref_clk);
		#1 cr(1'b0);
		sbc_mode = wecu_pkg::wecu_mode_normal;
		wr(8'h64, 8'h02);
	endtask
	task automatic t_timer();
		logic [7:0] q;
		ev(8'h00, 8'h03, 8'h00, 1'b0);
		wr(8'h62, 8'h01);
		// a stopped timer lets the pending bit show the moment normal returns
		mc(wecu_pkg::wecu_mode_overtemp, 1'b1, 1'b0);
		mc(wecu_pkg::wecu_mode_normal, 1'b1, 1'b1);
		wr(8'h62, 8'h02);
		ev(8'h00, 8'h04, 8'h00, 1'b0);
		cr(1'b0);
		repeat (8) @(posedge ref_clk);
		#1 cr(1'b1);
		rd(8'h62, 8'h04);
		mc(wecu_pkg::wecu_mode_standby, 1'b1, 1'b1);
		mc(wecu_pkg::wecu_mode_standby, 1'b0, 1'b0);
		mc(wecu_pkg::wecu_mode_off, 1'b1, 1'b0);
		mc(wecu_pkg::wecu_mode_forced, 1'b1, 1'b0);
		mc(wecu_pkg::wecu_mode_normal, 1'b1, 1'b1);
		wr(8'h62, 8'h04);
		wr(8'h23, 8'hff);
		rd(8'h23, 8'hdf);
		ev(8'h00, 8'h00, 8'h00, 1'b1);
		rd(8'h63, 8'h01);
		wr(8'h63, 8'h01);
		// twelve-bit write is torn: nothing lands, spi fail is captured
		host.xfer(16'h0800, 12, q);
		rd(8'h61, 8'h02);
		rd(8'h04, 8'hee);
		wr(8'h61, 8'h02);
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		t_reset();
		t_capture();
		t_enable();
		t_sleep();
		t_wake();
		t_timer();
		end_of_test();
	end
endmodule
